// ==== verilog/codec_rate_consts.svh ====
/*
 codec_rate_consts.svh: register offsets, field positions, reset values and
 timing counts of the codec rate and filter control block.
 assumes: included by bare name, after nothing else.
*/
`ifndef CODEC_RATE_CONSTS_SVH
`define CODEC_RATE_CONSTS_SVH

// register byte offsets
`define ADDR_CTRL1 8'h00
`define ADDR_CTRL2 8'h04
`define ADDR_CTRL3 8'h08
`define ADDR_CTRL4 8'h0C
`define ADDR_CTRL5 8'h10
`define ADDR_STATUS 8'h14

// field positions
`define C1_DLB 1
`define C1_ALB 2
`define C1_MIC_BIAS_SEL 3
`define C1_INT_OVF 4
`define C1_IIR_SEL 5
`define C1_DEC_OVF 7
`define C2_BYPASS 6
`define C3_OSR_LSB 0
`define C4_M_LSB 0
`define C4_N_LSB 8
`define C4_P_LSB 16
`define C5_GAIN_LSB 0
`define C5_SIDE_LSB 8
`define ST_FRAMES_LSB 0
`define ST_PLL 16
`define ST_BYPASS 17
`define ST_IIR 18

// reset values (m, n and p codes hold value minus one)
`define M_RESET 7'h00
`define N_RESET 4'h0
`define P_RESET 3'h7
`define OSR_RESET 2'h0
`define GAIN_RESET 5'h00
`define SIDE_RESET 3'h0

// timing
`define FS_BASE_DIV_LOG2 4
`define PERIOD_RESET 19'h00080
`define MOD_INC_NORMAL 19'h00080
`define MOD_INC_BYPASS 19'h00020
`define SERIAL_DIV 4'h4
`define DEC_FIR_DELAY 17
`define INT_FIR_DELAY 18
`define SINC_SHIFT_NORMAL 8
`define SINC_SHIFT_BYPASS 10

// gain encoding
`define GAIN_LINEAR_MAX 5'h1C
`define GAIN_CODE_48DB 5'h1D
`define GAIN_48DB 8'h60
`define GAIN_54DB 8'h6C

`endif

// ==== verilog/codec_rate_pkg.sv ====
/*
 codec_rate_pkg: types shared by the rate control core and its strobe generator.
 assumes: compiled before every other design file.
*/
package codec_rate_pkg;
   typedef enum logic [1:0] {OSR_128 = 2'h0, OSR_256 = 2'h1, OSR_512 = 2'h2} osr_t;
   typedef logic signed [15:0] sample_t;
   typedef logic [7:0] apb_addr_t;
   typedef struct packed {
      logic [6:0] m_code;
      logic [3:0] n_code;
      logic [2:0] p_code;
      logic bypass;
      logic [1:0] osr;
   } rate_cfg_t;
endpackage : codec_rate_pkg

// ==== verilog/frame_if.sv ====
/*
 frame_if: requested rate settings and the resulting frame and modulator ticks.
 assumes: one generator and one control core on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
   import codec_rate_pkg::*;
   rate_cfg_t req;
   logic frame_strobe;
   logic adc_tick;
   logic dac_tick;
   logic serial_tick;
   logic bypass_act;
   logic pll_act;
   osr_t osr_act;
   modport gen (input req, output frame_strobe, adc_tick, dac_tick, serial_tick,
      bypass_act, pll_act, osr_act);
   modport ctl (output req, input frame_strobe, adc_tick, dac_tick, serial_tick,
      bypass_act, pll_act, osr_act);
endinterface : frame_if
`default_nettype wire

// ==== verilog/frame_strobe_gen.sv ====
/*
 frame_strobe_gen: divides pclk (the master clock) into the frame strobe and
 spreads the modulator ticks evenly over each frame.
 assumes: pclk is the master clock; settings change only at a frame edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "codec_rate_consts.svh"
module frame_strobe_gen (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // towards the control core
   frame_if.gen fif
);
   import codec_rate_pkg::*;
   logic [18:0] period_q, cnt_q, adc_acc_q, dac_acc_q;
   logic [18:0] full_d, period_d, adc_inc, dac_inc, adc_sum, dac_sum;
   logic [7:0] m_val;
   logic [4:0] n_val;
   logic [3:0] p_val;
   logic [3:0] ser_q;
   logic bypass_q, pll_q, strobe;
   osr_t osr_q;

   always_comb begin
      m_val = {1'b0, fif.req.m_code} + 8'h01;
      n_val = {1'b0, fif.req.n_code} + 5'h01;
      p_val = {1'b0, fif.req.p_code} + 4'h1;
      // coarse mode is simply p code 7, so one product covers both modes
      full_d = (19'(m_val) * 19'(n_val) * 19'(p_val)) << `FS_BASE_DIV_LOG2;
      // ratio bounds against chain size and transfer mode stay with software
      period_d = fif.req.bypass ? (full_d >> 2) : full_d;
      strobe = (cnt_q == period_q - 19'h00001);
      adc_inc = bypass_q ? `MOD_INC_BYPASS : `MOD_INC_NORMAL;
      case (osr_q)
         OSR_256: dac_inc = adc_inc << 1;
         OSR_512: dac_inc = adc_inc << 2;
         default: dac_inc = adc_inc;
      endcase
      adc_sum = adc_acc_q + adc_inc;
      dac_sum = dac_acc_q + dac_inc;
   end

   // new ratios take effect only at a frame edge, never mid-frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_q <= `PERIOD_RESET;
         bypass_q <= 1'b0;
         pll_q <= 1'b0;
         osr_q <= OSR_128;
      end else if (strobe) begin
         period_q <= period_d;
         bypass_q <= fif.req.bypass;
         pll_q <= (fif.req.p_code != `P_RESET);
         // the spare code 3 runs as ratio 128, so the port never shows a code outside the enum
         osr_q <= (fif.req.osr == 2'h3) ? OSR_128 : osr_t'(fif.req.osr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 19'h00000;
      else if (strobe) cnt_q <= 19'h00000;
      else cnt_q <= cnt_q + 19'h00001;
   end

   // fractional spreading; periods shorter than the increment saturate at one tick a cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_acc_q <= 19'h00000;
         dac_acc_q <= 19'h00000;
      end else if (strobe) begin
         adc_acc_q <= 19'h00000;
         dac_acc_q <= 19'h00000;
      end else begin
         adc_acc_q <= (adc_sum >= period_q) ? adc_sum - period_q : adc_sum;
         dac_acc_q <= (dac_sum >= period_q) ? dac_sum - period_q : dac_sum;
      end
   end

   // serial clocking counts the master clock itself, never the multiplied one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ser_q <= 4'h0;
      else if (ser_q == `SERIAL_DIV - 4'h1) ser_q <= 4'h0;
      else ser_q <= ser_q + 4'h1;
   end

   assign fif.frame_strobe = strobe;
   // the strobe cycle carries the last tick, so a frame no shorter than the increment holds the full count: 128 adc ticks, or 32 in bypass
   assign fif.adc_tick = (adc_sum >= period_q);
   assign fif.dac_tick = (dac_sum >= period_q);
   assign fif.serial_tick = (ser_q == `SERIAL_DIV - 4'h1);
   assign fif.bypass_act = bypass_q;
   assign fif.pll_act = pll_q;
   assign fif.osr_act = osr_q;
endmodule : frame_strobe_gen
`default_nettype wire

// ==== verilog/codec_rate_filter_control.sv ====
/*
 codec_rate_filter_control: apb register file, frame rate control, decimation
 and interpolation filtering, loopback and sidetone of one codec channel.
 assumes: pclk is the master clock; the dsp port shares pclk; the modulator
 bit arrives asynchronously.
*/
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "codec_rate_consts.svh"
module codec_rate_filter_control (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire codec_rate_pkg::apb_addr_t paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // dsp frame side
   input wire codec_rate_pkg::sample_t dac_sample_in,
   output logic frame_strobe,
   output logic serial_clk_tick,
   output codec_rate_pkg::sample_t adc_sample,
   // modulator side
   input wire logic adc_mod_bit,
   output logic dac_mod_bit,
   output logic adc_mod_tick,
   output logic dac_mod_tick,
   output logic pll_enable,
   // analog settings
   output logic analog_loopback_en,
   output logic microphone_bias_select,
   output logic [7:0] pga_gain_half_db,
   output logic [2:0] sidetone_level,
   output codec_rate_pkg::osr_t dac_osr
);
   import codec_rate_pkg::*;

   function automatic logic [5:0] reg_sel(input apb_addr_t a);
      if (a == `ADDR_CTRL1) reg_sel = 6'h01;
      else if (a == `ADDR_CTRL2) reg_sel = 6'h02;
      else if (a == `ADDR_CTRL3) reg_sel = 6'h04;
      else if (a == `ADDR_CTRL4) reg_sel = 6'h08;
      else if (a == `ADDR_CTRL5) reg_sel = 6'h10;
      else if (a == `ADDR_STATUS) reg_sel = 6'h20;
      else reg_sel = 6'h00;
   endfunction : reg_sel

   function automatic logic [16:0] sat16(input logic signed [17:0] v);
      if (v > 18'sh07FFF) sat16 = {1'b1, 16'h7FFF};
      else if (v < 18'sh38000) sat16 = {1'b1, 16'h8000};
      else sat16 = {1'b0, v[15:0]};
   endfunction : sat16

   // symmetric 1-2-1 kernel; the delay line in front sets the group delay
   function automatic sample_t fir3(input sample_t a, input sample_t b, input sample_t c);
      logic signed [17:0] s;
      begin
         s = 18'(a) + (18'(b) <<< 1) + 18'(c);
         fir3 = sample_t'(s >>> 2);
      end
   endfunction : fir3

   // one-pole low pass: next = y + (x - y)/4
   function automatic sample_t iir1(input sample_t y, input sample_t x);
      logic signed [17:0] s;
      begin
         s = 18'(y) + ((18'(x) - 18'(y)) >>> 2);
         iir1 = sample_t'(s);
      end
   endfunction : iir1

   function automatic logic [7:0] gain_half_db(input logic [4:0] code);
      if (code <= `GAIN_LINEAR_MAX) gain_half_db = {3'h0, code} * 8'h03;
      else if (code == `GAIN_CODE_48DB) gain_half_db = `GAIN_48DB;
      else gain_half_db = `GAIN_54DB;
   endfunction : gain_half_db

   // modulator bit synchroniser
   logic mod_meta_q, mod_sync_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_meta_q <= 1'b0;
         mod_sync_q <= 1'b0;
      end else begin
         mod_meta_q <= adc_mod_bit;
         mod_sync_q <= mod_meta_q;
      end
   end

   // register fields
   logic dlb_q, alb_q, mic_bias_q, iir_sel_q, bypass_q, iir_act_q;
   logic dec_ovf_q, int_ovf_q;
   logic [1:0] osr_q;
   logic [6:0] m_q;
   logic [3:0] n_q;
   logic [2:0] p_q;
   logic [4:0] gain_q;
   logic [7:0] gain_db_q;
   logic [2:0] side_q;
   logic [15:0] frame_cnt_q;
   logic [31:0] rdata_d, prdata_q;
   logic [5:0] sel;
   logic setup, access, wr_en, rd_clr;

   frame_if fif ();

   always_comb begin
      sel = reg_sel(paddr);
      setup = psel && !penable;
      access = psel && penable;
      wr_en = access && pwrite;
      rd_clr = access && !pwrite && sel[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dlb_q <= 1'b0;
         alb_q <= 1'b0;
         mic_bias_q <= 1'b0;
         iir_sel_q <= 1'b0;
         bypass_q <= 1'b0;
         osr_q <= `OSR_RESET;
         m_q <= `M_RESET;
         n_q <= `N_RESET;
         p_q <= `P_RESET;
         gain_q <= `GAIN_RESET;
         gain_db_q <= 8'h00;
         side_q <= `SIDE_RESET;
      end else if (wr_en) begin
         if (sel[0]) begin
            dlb_q <= pwdata[`C1_DLB];
            alb_q <= pwdata[`C1_ALB];
            mic_bias_q <= pwdata[`C1_MIC_BIAS_SEL];
            iir_sel_q <= pwdata[`C1_IIR_SEL];
         end
         if (sel[1]) bypass_q <= pwdata[`C2_BYPASS];
         if (sel[2]) osr_q <= pwdata[`C3_OSR_LSB +: 2];
         if (sel[3]) begin
            m_q <= pwdata[`C4_M_LSB +: 7];
            n_q <= pwdata[`C4_N_LSB +: 4];
            p_q <= pwdata[`C4_P_LSB +: 3];
         end
         if (sel[4]) begin
            gain_q <= pwdata[`C5_GAIN_LSB +: 5];
            gain_db_q <= gain_half_db(pwdata[`C5_GAIN_LSB +: 5]);
            side_q <= pwdata[`C5_SIDE_LSB +: 3];
         end
      end
   end

   always_comb begin
      rdata_d = 32'h00000000;
      if (sel[0]) begin
         rdata_d[`C1_DLB] = dlb_q;
         rdata_d[`C1_ALB] = alb_q;
         rdata_d[`C1_MIC_BIAS_SEL] = mic_bias_q;
         rdata_d[`C1_INT_OVF] = int_ovf_q;
         rdata_d[`C1_IIR_SEL] = iir_sel_q;
         rdata_d[`C1_DEC_OVF] = dec_ovf_q;
      end else if (sel[1]) begin
         rdata_d[`C2_BYPASS] = bypass_q;
      end else if (sel[2]) begin
         rdata_d[`C3_OSR_LSB +: 2] = osr_q;
      end else if (sel[3]) begin
         rdata_d[`C4_M_LSB +: 7] = m_q;
         rdata_d[`C4_N_LSB +: 4] = n_q;
         rdata_d[`C4_P_LSB +: 3] = p_q;
      end else if (sel[4]) begin
         rdata_d[`C5_GAIN_LSB +: 5] = gain_q;
         rdata_d[`C5_SIDE_LSB +: 3] = side_q;
      end else if (sel[5]) begin
         rdata_d[`ST_FRAMES_LSB +: 16] = frame_cnt_q;
         rdata_d[`ST_PLL] = fif.pll_act;
         rdata_d[`ST_BYPASS] = fif.bypass_act;
         rdata_d[`ST_IIR] = iir_act_q;
      end
   end

   // read data is caught in the setup cycle and held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= 32'h00000000;
      else if (setup && !pwrite) prdata_q <= rdata_d;
   end

   // rate generator
   assign fif.req = '{m_code: m_q, n_code: n_q, p_code: p_q, bypass: bypass_q, osr: osr_q};

   frame_strobe_gen u_gen (
      .pclk(pclk),
      .presetn(presetn),
      .fif(fif.gen)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) iir_act_q <= 1'b0;
      else if (fif.frame_strobe) iir_act_q <= iir_sel_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) frame_cnt_q <= 16'h0000;
      else if (fif.frame_strobe) frame_cnt_q <= frame_cnt_q + 16'h0001;
   end

   // decimation: sinc accumulate-and-dump over the modulator ticks of one frame
   logic dac_mod_q, adc_in_bit;
   logic signed [9:0] sinc_acc_q, sinc_next;
   logic signed [17:0] sinc_scaled;
   logic [16:0] dec_sat;
   sample_t dec_line_q [0:`DEC_FIR_DELAY];
   sample_t dec_iir_q, dec_iir_next, dec_out, adc_q;

   always_comb begin
      adc_in_bit = alb_q ? dac_mod_q : mod_sync_q;
      sinc_next = sinc_acc_q;
      if (fif.adc_tick) sinc_next = sinc_acc_q + (adc_in_bit ? 10'sh001 : 10'sh3FF);
      if (fif.bypass_act) sinc_scaled = 18'(sinc_next) <<< `SINC_SHIFT_BYPASS;
      else sinc_scaled = 18'(sinc_next) <<< `SINC_SHIFT_NORMAL;
      dec_sat = sat16(sinc_scaled);
      dec_iir_next = iir1(dec_iir_q, sample_t'(dec_sat[15:0]));
      if (fif.bypass_act) dec_out = sample_t'(dec_sat[15:0]);
      else if (iir_act_q) dec_out = dec_iir_next;
      else dec_out = fir3(dec_line_q[`DEC_FIR_DELAY - 2], dec_line_q[`DEC_FIR_DELAY - 1],
         dec_line_q[`DEC_FIR_DELAY]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sinc_acc_q <= 10'sh000;
      else if (fif.frame_strobe) sinc_acc_q <= 10'sh000;
      else sinc_acc_q <= sinc_next;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_line_q[0] <= 16'sh0000;
         dec_iir_q <= 16'sh0000;
         adc_q <= 16'sh0000;
      end else if (fif.frame_strobe) begin
         dec_line_q[0] <= sample_t'(dec_sat[15:0]);
         dec_iir_q <= dec_iir_next;
         adc_q <= dec_out;
      end
   end

   // interpolation input: loopback source plus sidetone, saturated
   logic signed [17:0] int_sum;
   logic [16:0] int_sat;
   sample_t int_src, side_val, int_iir_q, int_iir_next, int_out, dac_word_q;
   sample_t int_line_q [0:`INT_FIR_DELAY];

   always_comb begin
      int_src = (dlb_q && !alb_q) ? adc_q : dac_sample_in;
      side_val = (side_q == 3'h0) ? 16'sh0000 : (adc_q >>> side_q);
      int_sum = 18'(int_src) + 18'(side_val);
      int_sat = sat16(int_sum);
      int_iir_next = iir1(int_iir_q, sample_t'(int_sat[15:0]));
      if (fif.bypass_act) int_out = sample_t'(int_sat[15:0]);
      else if (iir_act_q) int_out = int_iir_next;
      else int_out = fir3(int_line_q[`INT_FIR_DELAY - 2], int_line_q[`INT_FIR_DELAY - 1],
         int_line_q[`INT_FIR_DELAY]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_line_q[0] <= 16'sh0000;
         int_iir_q <= 16'sh0000;
         dac_word_q <= 16'sh0000;
      end else if (fif.frame_strobe) begin
         int_line_q[0] <= sample_t'(int_sat[15:0]);
         int_iir_q <= int_iir_next;
         dac_word_q <= int_out;
      end
   end

   // fir delay lines shift once a frame
   for (genvar k = 1; k <= `DEC_FIR_DELAY; k++) begin : g_dec_line
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) dec_line_q[k] <= 16'sh0000;
         else if (fif.frame_strobe) dec_line_q[k] <= dec_line_q[k - 1];
      end
   end
   for (genvar k = 1; k <= `INT_FIR_DELAY; k++) begin : g_int_line
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) int_line_q[k] <= 16'sh0000;
         else if (fif.frame_strobe) int_line_q[k] <= int_line_q[k - 1];
      end
   end

   // sinc hold feeding a first-order modulator, stepped at the dac tick rate
   logic [15:0] sdm_acc_q;
   logic [16:0] sdm_sum;
   always_comb begin
      sdm_sum = {1'b0, sdm_acc_q} + {1'b0, ~dac_word_q[15], dac_word_q[14:0]};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdm_acc_q <= 16'h0000;
         dac_mod_q <= 1'b0;
      end else if (fif.dac_tick) begin
         sdm_acc_q <= sdm_sum[15:0];
         dac_mod_q <= sdm_sum[16];
      end
   end

   // sticky overflow flags: a new overflow beats the read that clears them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_ovf_q <= 1'b0;
         int_ovf_q <= 1'b0;
      end else begin
         dec_ovf_q <= (fif.frame_strobe && dec_sat[16]) ||
            (dec_ovf_q && !(rd_clr && prdata_q[`C1_DEC_OVF]));
         int_ovf_q <= (fif.frame_strobe && int_sat[16]) ||
            (int_ovf_q && !(rd_clr && prdata_q[`C1_INT_OVF]));
      end
   end

   // outputs
   assign pready = 1'b1;
   assign pslverr = access && (sel == 6'h00);
   assign prdata = prdata_q;
   assign frame_strobe = fif.frame_strobe;
   assign serial_clk_tick = fif.serial_tick;
   assign adc_sample = adc_q;
   assign dac_mod_bit = dac_mod_q;
   assign adc_mod_tick = fif.adc_tick;
   assign dac_mod_tick = fif.dac_tick;
   assign pll_enable = fif.pll_act;
   assign analog_loopback_en = alb_q;
   assign microphone_bias_select = mic_bias_q;
   assign pga_gain_half_db = gain_db_q;
   assign sidetone_level = side_q;
   assign dac_osr = fif.osr_act;
endmodule : codec_rate_filter_control
`default_nettype wire

// ==== verification/codec_rate_props.sv ====
/* codec_rate_props: port assertions of the codec rate block.
   assumes: bound to the design top; one pclk domain, presetn async low. */
`timescale 1ns/1ps
`default_nettype none
module codec_rate_props (
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire codec_rate_pkg::apb_addr_t paddr,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // frame side
   input wire logic frame_strobe,
   input wire logic serial_clk_tick,
   input wire logic adc_mod_tick,
   input wire logic dac_mod_tick,
   input wire logic pll_enable,
   input wire codec_rate_pkg::sample_t adc_sample,
   input wire codec_rate_pkg::osr_t dac_osr
);
   import codec_rate_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence gap3;
      !serial_clk_tick [*3] ##1 serial_clk_tick;
   endsequence
   a_serial_div4: assert property (serial_clk_tick |=> gap3)
      else $error("serial tick not every four cycles");
   a_tick_at_close: assert property (frame_strobe |-> adc_mod_tick && dac_mod_tick)
      else $error("frame closed without its last modulator tick");
   a_strobe_pulse: assert property (frame_strobe |=> !frame_strobe)
      else $error("frame strobe longer than one cycle");
   a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
      |-> pslverr == (paddr > 8'h14))
      else $error("pslverr wrong for address");
   a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 8'h14
      |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_pll_boundary: assert property ($changed(pll_enable) |-> $past(frame_strobe))
      else $error("pll enable moved inside a frame");
   a_osr_boundary: assert property ($changed(dac_osr) |-> $past(frame_strobe))
      else $error("oversampling ratio moved inside a frame");
   a_sample_frame: assert property ($changed(adc_sample) |-> $past(frame_strobe))
      else $error("adc sample moved inside a frame");
endmodule : codec_rate_props
bind codec_rate_filter_control codec_rate_props props_u (.*);
`default_nettype wire

// ==== verification/dsp_port_model.sv ====
/* dsp_port_model: dsp side of the frame port, one dac word towards the design per frame.
   assumes: shares pclk with the design; words change only after a strobe. */
`timescale 1ns/1ps
`default_nettype none
module dsp_port_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // frame port
   input wire logic frame_strobe,
   output codec_rate_pkg::sample_t dac_sample_in,
   output var int frames
);
   import codec_rate_pkg::*;
   // the design takes the word at the strobe edge, so the next one follows it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_sample_in <= 16'sh0000;
         frames <= 0;
      end else if (frame_strobe) begin
         dac_sample_in <= dac_sample_in + 16'sh0123;
         frames <= frames + 1;
      end
   end
endmodule : dsp_port_model
`default_nettype wire

// ==== verification/tb_top.sv ====
/* tb_top: register, frame rate and filter tests of the codec rate block.
   assumes: design, checker and dsp_port_model compiled first; pclk 125 MHz. */
`timescale 1ns/1ps
`default_nettype none
`include "codec_rate_consts.svh"
module tb_top;
   import codec_rate_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic adc_mod_bit = 1'b1;
   apb_addr_t paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
   logic pready, pslverr, frame_strobe, serial_clk_tick, dac_mod_bit, adc_mod_tick;
   logic dac_mod_tick, pll_enable, analog_loopback_en, microphone_bias_select;
   logic [7:0] pga_gain_half_db, g;
   logic [2:0] sidetone_level;
   sample_t dac_sample_in, adc_sample;
   osr_t dac_osr;
   int n_mismatch = 0, check_count = 0, cyc = 0, frames;
   realtime t0;
   always #4 pclk = ~pclk;
   codec_rate_filter_control dut_u (.*);
   dsp_port_model dsp_u (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // idle edge at the end keeps two calls from driving in one time step
   task automatic apb(input logic wr, input apb_addr_t a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input apb_addr_t a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd_q & m, exp);
   endtask : rd
   task automatic wait_fs();
      @(posedge pclk iff frame_strobe === 1'b1);
   endtask : wait_fs
   // first strobe takes pending settings, the second closes one new frame
   task automatic per(input int exp);
      wait_fs();
      t0 = $realtime;
      wait_fs();
      chk(32'(int'(($realtime - t0) / 8.0)), 32'(exp));
   endtask : per
   task automatic tally_and_finish();
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ADDR_CTRL3, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(`ADDR_CTRL4, 32'hFFFF_FFFF, 32'h0007_0000);
      rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
      per(128);
      // fine ratios keep 125 MHz over P inside 10..25 MHz and M*N*P at least 2
      apb(1'b1, `ADDR_CTRL4, 32'h0006_0000);
      chk(pll_enable, 32'h0);
      per(112);
      chk(pll_enable, 32'h1);
      apb(1'b1, `ADDR_CTRL4, 32'h0007_0F7F);
      rd(`ADDR_CTRL4, 32'hFFFF_FFFF, 32'h0007_0F7F);
      apb(1'b1, `ADDR_CTRL4, 32'h0004_0001);
      per(160);
      apb(1'b1, `ADDR_CTRL4, 32'h0007_0003);
      apb(1'b1, `ADDR_CTRL2, 32'hFFFF_FFFF);
      per(128);
      rd(`ADDR_STATUS, 32'hFFFF_0000, 32'h0002_0000);
      chk(rd_q & 32'h0000_FFFF, 32'(frames[15:0]));
      apb(1'b1, `ADDR_CTRL2, 32'h0000_0000);
      for (int k = 1; k < 4; k++) begin
         apb(1'b1, `ADDR_CTRL3, 32'(k));
         wait_fs();
         @(posedge pclk);
         chk(dac_osr, (k == 3) ? 32'h0 : 32'(k));
      end
      apb(1'b1, `ADDR_CTRL1, 32'h0000_002E);
      chk(analog_loopback_en, 32'h1);
      chk(microphone_bias_select, 32'h1);
      rd(`ADDR_CTRL1, 32'h0000_006F, 32'h0000_002E);
      for (int c = 0; c < 32; c++) begin
         g = (c < 29) ? 8'(c * 3) : ((c == 29) ? 8'h60 : 8'h6C);
         apb(1'b1, `ADDR_CTRL5, 32'(c) | (32'(c % 8) << 8));
         chk(pga_gain_half_db, g);
         chk(sidetone_level, 32'(c % 8));
      end
      apb(1'b1, `ADDR_CTRL5, 32'h0000_0000);
      apb(1'b1, `ADDR_CTRL1, 32'h0000_0000);
      apb(1'b1, `ADDR_CTRL4, 32'h0007_0000);
      // a steady one bit saturates the sinc sum; the fir needs 18 frames to fill
      repeat (24) wait_fs();
      @(posedge pclk);
      chk(adc_sample, 32'h0000_7FFF);
      rd(`ADDR_CTRL1, 32'h0000_0080, 32'h0000_0080);
      rd(`ADDR_CTRL1, 32'h0000_0080, 32'h0000_0000);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
